// *** rmd_addr.sv ***
package rmd_pkg;
  // Opcode fields
  localparam logic [5:0] OP_MOVE_FILE = 6'h14;
  localparam logic [3:0] OP_FILE_COPY = 4'hC;
  localparam logic [3:0] OP_SECOND = 4'hF;
  // Addressing constants
  localparam logic [7:0] IDX_LIMIT = 8'h5F;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [11:0] ADDR_WREG = 12'hFE8;
  localparam logic [11:0] ADDR_PC_LOW = 12'hFF9;
  localparam logic [11:0] ADDR_STACK_HIGH = 12'hFFE;
  localparam logic [11:0] ADDR_STACK_UPPER = 12'hFFF;
  localparam logic [11:0] ADDR_RESET = 12'h000;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  // Instruction cycle phases
  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q3 = 2'h2;
  localparam logic [1:0] PH_Q4 = 2'h3;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_MOVE = 4'h2,
    ST_FF_SRC = 4'h4,
    ST_FF_DST = 4'h8
  } rmd_st_t;

  typedef struct packed {
    logic [11:0] addr;
    logic rd_en;
    logic wr_en;
    logic [7:0] wdata;
  } rmd_mem_t;

  typedef struct packed {
    logic [1:0] phase;
    rmd_st_t st;
    logic to_w;
    logic [7:0] data;
    logic [7:0] w;
    logic flag_n;
    logic flag_z;
    logic refused;
    rmd_mem_t mem;
  } rmd_state_t;
endpackage

`timescale 1ns/10ps
module rmd_addr_gen
  import rmd_pkg::*;
(
  // Operand
  input wire logic [7:0] file_addr,
  input wire logic bank_access,
  // Context
  input wire logic [3:0] bank_select_reg,
  input wire logic ext_instr_en,
  input wire logic [11:0] index_base,
  // Result
  output logic [11:0] data_addr
);
  always_comb
  begin
    if (bank_access)
      data_addr = {bank_select_reg, file_addr}; // RULE3
    else if (ext_instr_en && file_addr <= IDX_LIMIT)
      data_addr = index_base + {4'h0, file_addr}; // RULE4
    else if (file_addr < ACCESS_SPLIT)
      data_addr = {ACCESS_LO_BANK, file_addr}; // RULE2
    else
      data_addr = {ACCESS_HI_BANK, file_addr}; // RULE2
  end
endmodule

// *** rmd_core.sv ***
// Operation
// RULE1: With the destination bit 0 the moved byte goes to the working register, with 1 back to the file register.
// RULE2: With the bank access bit 0 the 8-bit file address selects a location in the access bank.
// RULE3: With the bank access bit 1 the bank select register is joined to the 8-bit file address.
// RULE4: With extended instructions on and access bit 0, file addresses up to 95 are offset from the index base.
// RULE5: The file address field is a full 8 bits, reaching any location of a 256-byte bank.
// RULE6: The register move updates only the negative and zero flags from the moved byte.
// RULE7: The register move is opcode 0101 00 d a f, one word, executed in one instruction cycle.
// RULE8: The file-to-file move takes two words and two cycles, sets no flags, and refuses protected destinations.
`timescale 1ns/10ps
module rmd_core
  import rmd_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Instruction stream
  input wire logic [15:0] instr_word,
  input wire logic instr_valid,
  output logic instr_ready,
  // Context
  input wire logic [3:0] bank_select_reg,
  input wire logic ext_instr_en,
  input wire logic [11:0] index_base,
  // Data memory
  output logic [11:0] mem_addr,
  output logic mem_rd_en,
  input wire logic [7:0] mem_rdata,
  output logic mem_wr_en,
  output logic [7:0] mem_wdata,
  // Core state
  output logic [7:0] w_reg,
  output logic flag_n,
  output logic flag_z,
  output logic ff_refused,
  output logic [1:0] q_phase
);
  rmd_state_t s;
  rmd_state_t next_s;
  logic [11:0] move_addr;
  logic is_move;
  logic is_copy;
  logic take;
  logic [7:0] rd_byte;

  ////////////////////////////////////////////////////////////////////////////
  // Address formation
  rmd_addr_gen u_addr (
    .file_addr(instr_word[7:0]), // RULE5
    .bank_access(instr_word[8]),
    .bank_select_reg(bank_select_reg),
    .ext_instr_en(ext_instr_en),
    .index_base(index_base),
    .data_addr(move_addr)
  );

  function automatic logic is_protected(input logic [11:0] a);
    is_protected = (a == ADDR_PC_LOW) || (a == ADDR_STACK_UPPER) || (a == ADDR_STACK_HIGH);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  assign is_move = (instr_word[15:10] == OP_MOVE_FILE); // RULE7
  assign is_copy = (instr_word[15:12] == OP_FILE_COPY); // RULE8
  assign instr_ready = (s.phase == PH_Q1) && (s.st == ST_IDLE || s.st == ST_FF_DST);
  assign take = instr_ready && instr_valid;
  assign rd_byte = (s.mem.addr == ADDR_WREG) ? s.w : mem_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    next_s = s;
    next_s.phase = s.phase + 2'h1;
    next_s.refused = 1'b0;
    case (s.phase)
      PH_Q1:
      begin
        if (take && s.st == ST_FF_DST)
        begin
          if (instr_word[15:12] == OP_SECOND)
          begin
            next_s.mem.addr = instr_word[11:0];
          end
        end
        else if (take && is_move)
        begin
          next_s.st = ST_MOVE; // RULE7
          next_s.to_w = ~instr_word[9];
          next_s.mem.addr = move_addr;
          next_s.mem.rd_en = 1'b1;
        end
        else if (take && is_copy)
        begin
          next_s.st = ST_FF_SRC; // RULE8
          next_s.mem.addr = instr_word[11:0];
          next_s.mem.rd_en = 1'b1;
        end
        else if (s.st == ST_FF_DST)
        begin
          next_s.phase = PH_Q1;
        end
      end
      PH_Q2:
      begin
        next_s.mem.rd_en = 1'b0;
      end
      PH_Q3:
      begin
        case (s.st)
          ST_MOVE:
          begin
            next_s.data = rd_byte;
            next_s.flag_n = rd_byte[7]; // RULE6
            next_s.flag_z = (rd_byte == ZERO_BYTE); // RULE6
            if (!s.to_w && s.mem.addr != ADDR_WREG)
            begin
              next_s.mem.wr_en = 1'b1; // RULE1
              next_s.mem.wdata = rd_byte;
            end
          end
          ST_FF_SRC:
          begin
            next_s.data = rd_byte;
          end
          ST_FF_DST:
          begin
            if (is_protected(s.mem.addr))
              next_s.refused = 1'b1; // RULE8
            else if (s.mem.addr != ADDR_WREG)
            begin
              next_s.mem.wr_en = 1'b1;
              next_s.mem.wdata = s.data;
            end
          end
          default:
          begin
            next_s.mem.wr_en = 1'b0;
          end
        endcase
      end
      PH_Q4:
      begin
        next_s.mem.wr_en = 1'b0;
        case (s.st)
          ST_MOVE:
          begin
            if (s.to_w || s.mem.addr == ADDR_WREG)
              next_s.w = s.data; // RULE1
            next_s.st = ST_IDLE;
          end
          ST_FF_SRC:
          begin
            next_s.st = ST_FF_DST; // RULE8
          end
          ST_FF_DST:
          begin
            if (s.mem.addr == ADDR_WREG)
              next_s.w = s.data;
            next_s.st = ST_IDLE;
          end
          default:
          begin
            next_s.st = ST_IDLE;
          end
        endcase
      end
      default:
      begin
        next_s.phase = PH_Q1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s.phase <= PH_Q1;
      s.st <= ST_IDLE;
      s.to_w <= 1'b0;
      s.data <= ZERO_BYTE;
      s.w <= ZERO_BYTE;
      s.flag_n <= 1'b0;
      s.flag_z <= 1'b0;
      s.refused <= 1'b0;
      s.mem.addr <= ADDR_RESET;
      s.mem.rd_en <= 1'b0;
      s.mem.wr_en <= 1'b0;
      s.mem.wdata <= ZERO_BYTE;
    end
    else
    begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign mem_addr = s.mem.addr;
  assign mem_rd_en = s.mem.rd_en;
  assign mem_wr_en = s.mem.wr_en;
  assign mem_wdata = s.mem.wdata;
  assign w_reg = s.w;
  assign flag_n = s.flag_n;
  assign flag_z = s.flag_z;
  assign ff_refused = s.refused;
  assign q_phase = s.phase;
endmodule

// *** rmd_core_sva.sv ***
`timescale 1ns/10ps
module rmd_core_sva
  import rmd_pkg::*;
(
  // Clock, reset, instruction
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [15:0] instr_word,
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire logic [3:0] bank_select_reg,
  // Memory and state
  input wire logic [11:0] mem_addr,
  input wire logic mem_rd_en,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_wr_en,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] w_reg,
  input wire logic flag_n,
  input wire logic flag_z,
  input wire logic ff_refused,
  input wire logic [1:0] q_phase
);
  logic go;
  logic mv;
  assign go = instr_valid && instr_ready && q_phase == 2'h0;
  assign mv = go && instr_word[15:10] == 6'h14;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  AST_RD: assert property (mv |=> mem_rd_en && q_phase == 2'h1)
    else $error("no read after move");
  AST_BANK: assert property (mv && instr_word[8] |=> mem_addr == {$past(bank_select_reg), $past(instr_word[7:0])})
    else $error("banked address wrong");
  AST_WB: assert property (mv && instr_word[9] |-> ##3 mem_wr_en && mem_wdata == $past(mem_rdata))
    else $error("write back wrong");
  AST_WW: assert property (mv && !instr_word[9] |-> ##3 !mem_wr_en ##1 w_reg == $past(mem_rdata, 2))
    else $error("working register wrong");
  AST_FLG: assert property (mv |-> ##3 flag_n == $past(mem_rdata[7]) && flag_z == ($past(mem_rdata) == 8'h00))
    else $error("flags wrong");
  AST_REF: assert property (ff_refused |-> !mem_wr_en && q_phase == 2'h3)
    else $error("refused move wrote");
  AST_RDY: assert property (instr_ready |-> q_phase == 2'h0)
    else $error("ready outside first phase");
  AST_FFS: assert property (go && instr_word[15:12] == 4'hC |=> ($stable(flag_n) && $stable(flag_z)) [*8])
    else $error("flags moved by copy");
endmodule
////////////////////////////////////////
bind rmd_core rmd_core_sva u_sva (.*);

// *** rmd_core_tb.sv ***
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end
module rmd_core_tb
  import rmd_pkg::*;
;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic instr_valid = 1'b0;
  logic [3:0] bank_select_reg = 4'h0;
  logic ext_instr_en = 1'b0;
  logic [11:0] index_base = 12'h000;
  logic [7:0] mem_rdata = 8'h00;
  logic instr_ready, mem_rd_en, mem_wr_en, flag_n, flag_z, ff_refused;
  logic [11:0] mem_addr, ea;
  logic [7:0] mem_wdata, w_reg, f, v;
  logic [1:0] q_phase;
  logic [31:0] rs = 32'h000019C5;
  logic [7:0] w = 8'h00;
  logic n = 1'b0;
  logic z = 1'b0;
  logic p;
  logic [11:0] pt [3] = '{12'hFF9, 12'hFFE, 12'hFFF};
  int n_mismatch = 0;
  int checked = 0;
  always #50 core_clk = ~core_clk;
  rmd_core u_dut (.*);
  ////////////////////////////////////////
  function logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task give_verdict();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task issue(input logic [15:0] iw);
    for (int k = 0; k < 9 && !instr_ready; k++)
      @(negedge core_clk);
    if (!instr_ready)
    begin
      n_mismatch++;
      give_verdict();
    end
    instr_word = iw;
    instr_valid = 1'b1;
    @(negedge core_clk);
    instr_valid = 1'b0;
  endtask
  task move_file(input logic d, input logic a);
    ea = a ? {bank_select_reg, f} : (ext_instr_en && f <= 8'h5F) ? index_base + f
      : {f >= 8'h60 ? 4'hF : 4'h0, f};
    issue({6'h14, d, a, f});
    `CHK(mem_addr, ea)
    `CHK(mem_rd_en, 1'b1)
    mem_rdata = v;
    repeat (2) @(negedge core_clk);
    mem_rdata = ~v;
    n = v[7];
    z = v == 8'h00;
    `CHK({flag_n, flag_z}, {n, z})
    `CHK(mem_wr_en, d)
    if (d)
      `CHK(mem_wdata, v)
    else
      w = v;
    @(negedge core_clk);
    `CHK(w_reg, w)
  endtask
  task ffmove(input logic [11:0] s, input logic [11:0] t);
    p = t == 12'hFF9 || t > 12'hFFD;
    issue({4'hC, s});
    `CHK(mem_addr, s)
    mem_rdata = v;
    repeat (2) @(negedge core_clk);
    mem_rdata = ~v;
    issue({4'hF, t});
    `CHK(mem_addr, t)
    repeat (2) @(negedge core_clk);
    `CHK({mem_wr_en, ff_refused, flag_n, flag_z}, {!p, p, n, z})
    if (!p)
      `CHK(mem_wdata, v)
  endtask
  initial
  begin
    repeat (4) @(negedge core_clk);
    resetn = 1'b1;
    for (int i = 0; i < 48; i++)
    begin
      v = 8'(rnd());
      if (i % 5 == 0)
        v = 8'h00;
      bank_select_reg = rs[11:8] & 4'hE;
      ext_instr_en = rs[12] || i < 4;
      index_base = rs[31:20] & 12'hEFF;
      f = i < 4 ? 8'h5E + 8'(i) : rs[23:16];
      if (f == 8'hE8)
        f = 8'hE7;
      move_file(rs[13], rs[14] && i > 3);
    end
    for (int j = 0; j < 6; j++)
    begin
      v = 8'(rnd());
      ffmove(rs[11:0] & 12'hEFF, j < 3 ? pt[j] : rs[27:16] & 12'hEFF);
    end
    give_verdict();
  end
endmodule
